// >>> design/ocs_pkg.sv
/*
 operating mode clock system package: mode codes, field widths, divider figures, shared structs.
 assumes nothing beyond a SystemVerilog compiler.
*/
package ocs_pkg;
  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_SLOW = 3'h0;
  localparam logic [2:0] MODE_FAST = 3'h1;
  localparam logic [2:0] MODE_LOWEST = 3'h2;
  localparam logic [2:0] MODE_PLL = 3'h3;
  localparam logic [2:0] MODE_WAKE = 3'h4;
  localparam logic [2:0] MODE_IDLE = 3'h5;
  localparam logic [2:0] MODE_RSVD = 3'h6;
  localparam logic [2:0] MODE_PLL_ALT = 3'h7;
  localparam logic [2:0] MODE_RESET = 3'h1;
  localparam int FACTOR_W = 4;
  localparam logic [3:0] FACTOR_RESET = 4'h0;
  localparam int IODIV_W = 4;
  localparam logic [3:0] IODIV_RESET = 4'h1;
  localparam int SLOW_DIV = 128;
  localparam logic [6:0] SLOW_LAST = 7'h7F;
  localparam int CHAIN_W = 18;
  localparam int LOCK_CYCLES = 16;
  localparam logic [4:0] LOCK_LAST = 5'h0F;
  localparam logic [3:0] WAKE_RESET_CYCLES = 4'h8;
  localparam logic [1:0] LOCK_SEL_PLL = 2'h0;

  typedef enum logic [1:0] {OCS_RUN, OCS_IDLE, OCS_WRST} ocs_state_t;

  typedef struct packed {
    logic bus_en;
    logic io_en;
    logic f0_en;
    logic f1_en;
  } ocs_clk_en_t;

  typedef struct packed {
    logic [1:0] presc_sel;
    logic [3:0] mux_choice;
    logic shared_pin_output_choice;
  } ocs_hw_opt_t;
endpackage

// >>> design/ocs_clock_system.sv
/*
 operating mode clock system: mode decode, pll model, i/o prescaler, divider chain,
 clock outputs, idle entry and wake reset.
 assumes the crystal clock is the module clock; derived clocks are one-cycle enables.
*/
// Operation
// RULE1 - three-bit mode field decodes slow fast lowest pll wake idle reserved pll_alt
// RULE2 - idle resets all but port registers, stops clocks, keeps auxiliary regulator; code zeroes clk_en and periph_en only, clock outputs keep running
// RULE3 - sram, can ram and port registers keep contents through idle
// RULE4 - wake source toggle in idle starts wake reset, pin low until internal resets clear
// RULE5 - after wake reset the mode field reads fast
// RULE6 - idle accepts the same wake sources as standby
// RULE7 - wake sources are configured wake port inputs and selected rtc period
// RULE8 - software sets rtc period, wake ports and port registers before idle
// RULE9 - system clock rate is crystal times factor plus one
// RULE10 - lock flag readable and routable to lock pin by enable and select
// RULE11 - i/o clock is system clock divided by integer m
// RULE12 - divider chain halves each stage giving f0 through f17
// RULE13 - per mode bus, i/o, f0, f1 rates follow the mode table
// RULE14 - with n equal 2m f1 equals crystal in fast, pll and slow
// RULE15 - divisors 1.5 and 2.5 give 33 and 20 percent duty
// RULE16 - output zero is prescaler then four-input mux chosen by two select bits
// RULE17 - prescaler outputs also go out as interrupt sources
// RULE18 - clock outputs keep running in slow mode
// RULE19 - software sets u-port pins to special output before using clocks
// RULE20 - option flag picks alternate output zero or output one for shared pin
`timescale 1ns/1ps
module ocs_clock_system (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mode_write,
  input wire logic [2:0] mode_wdata,
  input wire logic factor_write,
  input wire logic [3:0] multiplication_factor,
  input wire logic iodiv_write,
  input wire logic [3:0] io_clock_divider_reg,
  input wire logic [1:0] clock_output_select_reg,
  input wire logic lock_output_enable,
  input wire logic [1:0] lock_output_select,
  input wire ocs_pkg::ocs_hw_opt_t hw_opt,
  input wire logic [9:0] wake_port_enable,
  input wire logic [9:0] wake_port_in,
  input wire logic rtc_wake_enable,
  input wire logic rtc_wake_tick,
  input wire logic internal_reset_busy,
  output logic [2:0] operating_mode_field,
  output logic [3:0] pll_control_reg,
  output logic pll_lock_flag,
  output logic lock_output_pin,
  output ocs_pkg::ocs_clk_en_t clk_en,
  output logic [17:0] periph_en,
  output logic clock_output_zero,
  output logic clock_output_zero_alt,
  output logic clock_output_one,
  output logic shared_pin_out,
  output logic [1:0] presc_irq,
  output logic core_reset,
  output logic retain_ports,
  output logic main_regulator_on,
  output logic aux_regulator_on,
  output logic reset_pin_n
);
  ocs_pkg::ocs_state_t state;
  logic [3:0] factor;
  logic [3:0] iodiv;
  logic [4:0] lock_cnt;
  logic [6:0] slow_cnt;
  logic [3:0] sys_cnt;
  logic [3:0] io_cnt;
  logic [ocs_pkg::CHAIN_W-3:0] chain;
  logic [9:0] wake_prev;
  logic [3:0] wrst_cnt;
  logic [3:0] p15_cnt;
  logic [4:0] p25_cnt;
  logic [1:0] p2_cnt;
  logic p15;
  logic p25;
  logic p2;
  logic p1;
  logic [3:0] presc_bank;
  logic running;
  logic pll_mode;
  logic slow_tick;
  logic sys_tick;
  logic io_tick;
  logic wake_hit;
  logic [4:0] half_cnt;
  logic [5:0] half_sum;
  logic half_tick;
  logic [ocs_pkg::CHAIN_W-3:0] next_chain;

  function automatic logic is_pll(input logic [2:0] m);
    is_pll = (m == ocs_pkg::MODE_PLL) || (m == ocs_pkg::MODE_PLL_ALT);
  endfunction

  function automatic logic is_slowish(input logic [2:0] m);
    is_slowish = (m == ocs_pkg::MODE_SLOW) || (m == ocs_pkg::MODE_LOWEST);
  endfunction

  assign running = (state == ocs_pkg::OCS_RUN);
  assign pll_mode = is_pll(operating_mode_field);

  // mode field and idle/wake sequencing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      operating_mode_field <= ocs_pkg::MODE_RESET;
    end else if (state == ocs_pkg::OCS_WRST && wrst_cnt == 4'h0 && !internal_reset_busy) begin
      operating_mode_field <= ocs_pkg::MODE_FAST; // RULE5
    end else if (running && mode_write) begin
      operating_mode_field <= mode_wdata; // RULE1
    end
  end

  // rtc and wake port toggles are the standby wake set, reused for idle
  assign wake_hit = (|((wake_port_in ^ wake_prev) & wake_port_enable))
                    || (rtc_wake_enable && rtc_wake_tick); // RULE6 RULE7

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wake_prev <= 10'h000;
    end else begin
      wake_prev <= wake_port_in;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= ocs_pkg::OCS_RUN;
    end else begin
      unique case (state)
        ocs_pkg::OCS_RUN: begin
          if (operating_mode_field == ocs_pkg::MODE_IDLE) begin
            state <= ocs_pkg::OCS_IDLE; // RULE2
          end
        end
        ocs_pkg::OCS_IDLE: begin
          if (wake_hit) begin
            state <= ocs_pkg::OCS_WRST; // RULE4
          end
        end
        ocs_pkg::OCS_WRST: begin
          if (wrst_cnt == 4'h0 && !internal_reset_busy) begin
            state <= ocs_pkg::OCS_RUN; // RULE4
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrst_cnt <= 4'h0;
    end else if (state == ocs_pkg::OCS_IDLE && wake_hit) begin
      wrst_cnt <= ocs_pkg::WAKE_RESET_CYCLES;
    end else if (wrst_cnt != 4'h0) begin
      wrst_cnt <= wrst_cnt - 4'h1;
    end
  end

  // port registers and srams sit outside this reset; retain_ports tells them so
  assign core_reset = !running; // RULE2
  assign retain_ports = (state != ocs_pkg::OCS_RUN); // RULE3
  assign main_regulator_on = running; // RULE2
  assign aux_regulator_on = 1'b1; // RULE2 RULE3
  assign reset_pin_n = (state != ocs_pkg::OCS_WRST); // RULE4

  // pll control: factor zero bypasses, lock after a settle count
  always_ff @(posedge clock) begin
    if (!rst_n || !running) begin
      factor <= ocs_pkg::FACTOR_RESET;
    end else if (factor_write && !pll_mode) begin
      factor <= multiplication_factor; // RULE9
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || factor == 4'h0) begin
      lock_cnt <= 5'h00;
    end else if (factor_write && !pll_mode) begin
      lock_cnt <= 5'h00;
    end else if (lock_cnt != ocs_pkg::LOCK_LAST) begin
      lock_cnt <= lock_cnt + 5'h01;
    end
  end

  assign pll_lock_flag = (factor != 4'h0) && (lock_cnt == ocs_pkg::LOCK_LAST); // RULE10
  assign pll_control_reg = factor;
  assign lock_output_pin = lock_output_enable
                           && (lock_output_select == ocs_pkg::LOCK_SEL_PLL)
                           && pll_lock_flag; // RULE10

  always_ff @(posedge clock) begin
    if (!rst_n || !running) begin
      iodiv <= ocs_pkg::IODIV_RESET;
    end else if (iodiv_write) begin
      iodiv <= (io_clock_divider_reg == 4'h0) ? 4'h1 : io_clock_divider_reg; // RULE11
    end
  end

  // the crystal is the fastest clock here, so pll rates are enable ratios capped at one
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      slow_cnt <= 7'h00;
    end else begin
      slow_cnt <= slow_cnt + 7'h01;
    end
  end

  assign slow_tick = (slow_cnt == ocs_pkg::SLOW_LAST);

  // n/m ratio: accumulate n per crystal cycle, emit one i/o tick per m
  always_ff @(posedge clock) begin
    if (!rst_n || !pll_mode) begin
      sys_cnt <= 4'h0;
    end else if ({1'b0, sys_cnt} + 5'(factor) + 5'h01 >= 5'(iodiv)) begin
      sys_cnt <= 4'(({1'b0, sys_cnt} + 5'(factor) + 5'h01) - 5'(iodiv)); // RULE11
    end else begin
      sys_cnt <= sys_cnt + factor + 4'h1;
    end
  end

  assign sys_tick = ({1'b0, sys_cnt} + 5'(factor) + 5'h01 >= 5'(iodiv));

  // f1 needs its own n/2m ratio: f0 is capped at crystal, so halving it would lose n = 2m
  assign half_sum = {1'b0, half_cnt} + 6'(factor) + 6'h01;
  assign half_tick = (half_sum >= {1'b0, iodiv, 1'b0});

  always_ff @(posedge clock) begin
    if (!rst_n || !pll_mode) begin
      half_cnt <= 5'h00;
    end else if (half_tick) begin
      half_cnt <= 5'(half_sum - {1'b0, iodiv, 1'b0}); // RULE13
    end else begin
      half_cnt <= half_sum[4:0];
    end
  end

  always_comb begin
    clk_en = '0;
    io_tick = 1'b0;
    unique case (operating_mode_field)
      ocs_pkg::MODE_SLOW, ocs_pkg::MODE_LOWEST: begin
        clk_en.bus_en = running && slow_tick; // RULE13
        io_tick = running && slow_tick;
      end
      ocs_pkg::MODE_FAST: begin
        clk_en.bus_en = running;
        io_tick = running;
      end
      ocs_pkg::MODE_PLL, ocs_pkg::MODE_PLL_ALT: begin
        clk_en.bus_en = running;
        io_tick = running && sys_tick; // RULE13
      end
      default: begin
        io_tick = 1'b0;
      end
    endcase
    clk_en.io_en = io_tick;
    // f0 runs at crystal in slow modes too, keeping f1 steady when n = 2m
    clk_en.f0_en = (running && is_slowish(operating_mode_field)) ? 1'b1 : io_tick; // RULE14
    if (operating_mode_field == ocs_pkg::MODE_PLL) begin
      clk_en.f1_en = running && half_tick; // RULE13 RULE14
    end else begin
      clk_en.f1_en = clk_en.f0_en; // RULE13 RULE14
    end
  end

  // ripple chain below f1: each stage ticks on every second tick of the one below
  always_comb begin
    logic carry;
    carry = clk_en.f1_en;
    next_chain = chain;
    for (int i = 0; i < ocs_pkg::CHAIN_W - 2; i++) begin
      if (carry) begin
        next_chain[i] = !chain[i];
      end
      carry = carry && chain[i];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !running) begin
      chain <= '0;
    end else begin
      chain <= next_chain; // RULE12
    end
  end

  generate
    for (genvar g = 0; g < ocs_pkg::CHAIN_W; g++) begin : g_periph
      if (g == 0) begin : g_f0
        assign periph_en[g] = clk_en.f0_en;
      end else if (g == 1) begin : g_f1
        assign periph_en[g] = clk_en.f1_en;
      end else begin : g_fn
        assign periph_en[g] = clk_en.f1_en && (&chain[g-2:0]); // RULE12
      end
    end
  endgenerate

  // clock output prescalers run from the crystal so slow mode leaves them alone
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      p15_cnt <= 4'h0;
      p25_cnt <= 5'h00;
      p2_cnt <= 2'h0;
    end else begin
      p15_cnt <= (p15_cnt == 4'h2) ? 4'h0 : p15_cnt + 4'h1; // RULE18
      p25_cnt <= (p25_cnt == 5'h04) ? 5'h00 : p25_cnt + 5'h01;
      p2_cnt <= p2_cnt + 2'h1;
    end
  end

  // 1.5 = one pulse per three cycles of a 2x clock; high one of three = 33 percent
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      p15 <= 1'b0;
      p25 <= 1'b0;
      p2 <= 1'b0;
      p1 <= 1'b0;
    end else begin
      p15 <= (p15_cnt == 4'h0); // RULE15
      p25 <= (p25_cnt == 5'h00); // RULE15
      p2 <= p2_cnt[1];
      p1 <= !p1;
    end
  end

  assign presc_bank = {p25, p15, p2, p1};
  assign presc_irq = {presc_bank[hw_opt.presc_sel], p2}; // RULE17

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clock_output_zero <= 1'b0;
      clock_output_zero_alt <= 1'b0;
      clock_output_one <= 1'b0;
      shared_pin_out <= 1'b0;
    end else begin
      clock_output_zero <= hw_opt.mux_choice[clock_output_select_reg] // RULE16
                           && presc_bank[hw_opt.presc_sel];
      clock_output_zero_alt <= !(hw_opt.mux_choice[clock_output_select_reg]
                                 && presc_bank[hw_opt.presc_sel]);
      clock_output_one <= p2; // RULE18
      shared_pin_out <= hw_opt.shared_pin_output_choice ? p2
                        : !(hw_opt.mux_choice[clock_output_select_reg]
                            && presc_bank[hw_opt.presc_sel]); // RULE20
    end
  end

  property p_wake_fast;
    @(posedge clock) disable iff (!rst_n)
      (state == ocs_pkg::OCS_WRST && $rose(reset_pin_n) == 1'b0 && wrst_cnt == 4'h0
       && !internal_reset_busy) |=> (operating_mode_field == ocs_pkg::MODE_FAST);
  endproperty
  a_wake_fast: assert property (p_wake_fast) else $error("no fast after wake"); // RULE5

  sequence s_idle_wake;
    state == ocs_pkg::OCS_IDLE && wake_hit;
  endsequence
  property p_wake_pin;
    @(posedge clock) disable iff (!rst_n)
      s_idle_wake |=> !reset_pin_n [*8];
  endproperty
  a_wake_pin: assert property (p_wake_pin) else $error("reset pin not held"); // RULE4

  property p_idle_reset;
    @(posedge clock) disable iff (!rst_n)
      (state == ocs_pkg::OCS_IDLE) |-> (core_reset && retain_ports && !main_regulator_on);
  endproperty
  a_idle_reset: assert property (p_idle_reset) else $error("idle not powered down"); // RULE2

  property p_idle_clocks;
    @(posedge clock) disable iff (!rst_n)
      (state != ocs_pkg::OCS_RUN) |-> (clk_en == '0);
  endproperty
  a_idle_clocks: assert property (p_idle_clocks) else $error("clock in idle"); // RULE13

  property p_slow_bus;
    @(posedge clock) disable iff (!rst_n)
      (running && is_slowish(operating_mode_field) && clk_en.bus_en) |=>
        !(clk_en.bus_en && is_slowish(operating_mode_field)) [*8];
  endproperty
  a_slow_bus: assert property (p_slow_bus) else $error("slow bus too fast"); // RULE13

  property p_lock_pin;
    @(posedge clock) disable iff (!rst_n)
      lock_output_pin |-> (pll_lock_flag && lock_output_enable);
  endproperty
  a_lock_pin: assert property (p_lock_pin) else $error("lock pin without lock"); // RULE10

  property p_p15_duty;
    @(posedge clock) disable iff (!rst_n)
      $rose(p15) |=> !p15 [*2];
  endproperty
  a_p15_duty: assert property (p_p15_duty) else $error("1.5 duty wrong"); // RULE15

  property p_p25_duty;
    @(posedge clock) disable iff (!rst_n)
      $rose(p25) |=> !p25 [*4];
  endproperty
  a_p25_duty: assert property (p_p25_duty) else $error("2.5 duty wrong"); // RULE15

  property p_f1_steady;
    @(posedge clock) disable iff (!rst_n)
      (running && (operating_mode_field == ocs_pkg::MODE_FAST
                   || is_slowish(operating_mode_field)))
        |-> (clk_en.f1_en == clk_en.f0_en);
  endproperty
  a_f1_steady: assert property (p_f1_steady) else $error("f1 moved off f0"); // RULE14

  property p_chain_half;
    @(posedge clock) disable iff (!rst_n)
      periph_en[2] |=> !periph_en[2];
  endproperty
  a_chain_half: assert property (p_chain_half) else $error("f2 not half of f1"); // RULE12
endmodule

// >>> verif/ocs_partner.sv
/*
 far side model: wake port pins, rtc wake tick and the internal reset sources.
 assumes the bench pulses port_req and rtc_req for one cycle at a time.
*/
`timescale 1ns/1ps
module ocs_partner (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic port_req,
  input wire logic [3:0] port_sel,
  input wire logic rtc_req,
  input wire logic reset_pin_n,
  output logic [9:0] wake_port_in,
  output logic rtc_wake_tick,
  output logic internal_reset_busy
);
  logic [3:0] busy_cnt;
  // a port pin toggles once per request and then keeps its level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wake_port_in <= 10'h000;
    end else if (port_req) begin
      wake_port_in[port_sel] <= ~wake_port_in[port_sel];
    end
  end
  always_ff @(posedge clock) begin
    rtc_wake_tick <= rst_n && rtc_req;
  end
  // sources stay busy longer than the fixed wake reset, so the pin must wait on them
  always_ff @(posedge clock) begin
    if (!rst_n || reset_pin_n) begin
      busy_cnt <= 4'h0;
    end else if (busy_cnt != 4'hC) begin
      busy_cnt <= busy_cnt + 4'h1;
    end
  end
  assign internal_reset_busy = !reset_pin_n && busy_cnt != 4'hC;
endmodule

// >>> verif/ocs_clock_system_tb.sv
/*
 self-checking bench: mode table, pll lock, clock output, idle entry and wake reset.
 assumes the design and ocs_partner are compiled first.
*/
`timescale 1ns/1ps
module ocs_clock_system_tb;
  typedef struct {logic [2:0] mode; logic [3:0] m; int bus; int io; int f0; int f1;} ocs_row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic mode_write = 1'b0;
  logic [2:0] mode_wdata = 3'h1;
  logic factor_write = 1'b0;
  logic [3:0] multiplication_factor = 4'h0;
  logic iodiv_write = 1'b0;
  logic [3:0] io_clock_divider_reg = 4'h1;
  logic lock_output_enable = 1'b1;
  logic [1:0] lock_output_select = 2'h0;
  logic [9:0] wake_port_enable = 10'h000;
  logic rtc_wake_enable = 1'b0;
  logic port_req = 1'b0;
  logic [3:0] port_sel = 4'h0;
  logic rtc_req = 1'b0;
  logic [2:0] operating_mode_field;
  logic [3:0] pll_control_reg;
  logic pll_lock_flag, lock_output_pin, clock_output_one, core_reset, retain_ports;
  logic clock_output_zero, clock_output_zero_alt, shared_pin_out;
  logic [1:0] presc_irq;
  logic [1:0] co_sel = 2'h1;
  ocs_pkg::ocs_hw_opt_t hw_opt = 7'h15;
  logic main_regulator_on, aux_regulator_on, reset_pin_n, rtc_wake_tick, internal_reset_busy;
  logic [9:0] wake_port_in;
  logic [17:0] periph_en;
  ocs_pkg::ocs_clk_en_t clk_en;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  int cnt[6];
  logic b;
  // n=2, m=1 keeps f1 at crystal; m=4 puts f1 below io and f0 in pll mode only
  ocs_row_t rows[8] = '{
    '{3'h0, 4'h1, 2, 2, 256, 256}, '{3'h1, 4'h1, 256, 256, 256, 256},
    '{3'h3, 4'h1, 256, 256, 256, 256}, '{3'h3, 4'h4, 256, 128, 128, 64},
    '{3'h7, 4'h4, 256, 128, 128, 128}, '{3'h2, 4'h4, 2, 2, -1, -1},
    '{3'h4, 4'h4, 0, 0, 0, 0}, '{3'h6, 4'h4, 0, 0, 0, 0}};

  always #4 clock = ~clock;

  ocs_clock_system ocs_clock_system_i (.clock(clock), .rst_n(rst_n),
    .mode_write(mode_write), .mode_wdata(mode_wdata), .factor_write(factor_write),
    .multiplication_factor(multiplication_factor), .iodiv_write(iodiv_write),
    .io_clock_divider_reg(io_clock_divider_reg), .clock_output_select_reg(co_sel),
    .lock_output_enable(lock_output_enable), .lock_output_select(lock_output_select),
    .hw_opt(hw_opt), .wake_port_enable(wake_port_enable), .wake_port_in(wake_port_in),
    .rtc_wake_enable(rtc_wake_enable), .rtc_wake_tick(rtc_wake_tick),
    .internal_reset_busy(internal_reset_busy), .operating_mode_field(operating_mode_field),
    .pll_control_reg(pll_control_reg), .pll_lock_flag(pll_lock_flag),
    .lock_output_pin(lock_output_pin), .clk_en(clk_en), .periph_en(periph_en),
    .clock_output_zero(clock_output_zero), .clock_output_zero_alt(clock_output_zero_alt),
    .clock_output_one(clock_output_one), .shared_pin_out(shared_pin_out),
    .presc_irq(presc_irq), .core_reset(core_reset), .retain_ports(retain_ports),
    .main_regulator_on(main_regulator_on), .aux_regulator_on(aux_regulator_on),
    .reset_pin_n(reset_pin_n));

  ocs_partner ocs_partner_i (.clock(clock), .rst_n(rst_n), .port_req(port_req),
    .port_sel(port_sel), .rtc_req(rtc_req), .reset_pin_n(reset_pin_n),
    .wake_port_in(wake_port_in), .rtc_wake_tick(rtc_wake_tick),
    .internal_reset_busy(internal_reset_busy));

  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_v(input logic [17:0] got, input logic [17:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // rate counts carry a phase slack of one pulse per window
  task automatic chk_n(input int got, input int exp, input string what);
    if (exp >= 0) begin
      total_checks++;
      if (got < exp - 1 || got > exp + 1) begin
        n_fail++;
        $display("FAIL %0t %s got %0d exp %0d", $time, what, got, exp);
      end
    end
  endtask

  task automatic set_mode(input logic [2:0] md, input logic [3:0] m);
    @(posedge clock);
    mode_write <= 1'b1;
    mode_wdata <= md;
    iodiv_write <= 1'b1;
    io_clock_divider_reg <= m;
    @(posedge clock);
    mode_write <= 1'b0;
    iodiv_write <= 1'b0;
  endtask

  task automatic measure();
    cnt = '{0, 0, 0, 0, 0, 0};
    repeat (256) begin
      @(negedge clock);
      cnt[0] += int'(clk_en.bus_en);
      cnt[1] += int'(clk_en.io_en);
      cnt[2] += int'(clk_en.f0_en);
      cnt[3] += int'(clk_en.f1_en);
      cnt[4] += int'(periph_en[2]);
      cnt[5] += int'(periph_en[3]);
    end
  endtask

  // prescalers run free from the crystal, so counts hold for any phase
  task automatic clock_out_case(input logic [6:0] opt, input logic [1:0] sel, input int hi_exp,
                                input int irq_exp);
    int hi;
    int irq_hi;
    int irq_lo;
    hi = 0;
    irq_hi = 0;
    irq_lo = 0;
    @(posedge clock);
    hw_opt <= opt;
    co_sel <= sel;
    repeat (4) @(negedge clock);
    repeat (60) begin
      @(negedge clock);
      hi += int'(clock_output_zero);
      irq_hi += int'(presc_irq[1]);
      irq_lo += int'(presc_irq[0]);
      chk_v(clock_output_zero_alt, !clock_output_zero, "alternate");
      chk_v(shared_pin_out, opt[0] ? clock_output_one : clock_output_zero_alt, "pin");
    end
    chk_n(hi, hi_exp, "output zero rate");
    chk_n(irq_hi, irq_exp, "prescaler irq");
    chk_n(irq_lo, 30, "output one irq");
    $display("test clock out %h done", opt);
  endtask

  task automatic idle_wake(input logic use_rtc);
    int low;
    low = 0;
    @(posedge clock);
    wake_port_enable <= 10'h008;
    rtc_wake_enable <= use_rtc;
    set_mode(ocs_pkg::MODE_IDLE, 4'h1);
    repeat (2) @(negedge clock);
    chk_v(core_reset, 1'b1, "core reset");
    chk_v(main_regulator_on, 1'b0, "main regulator");
    chk_v(aux_regulator_on, 1'b1, "aux regulator");
    chk_v(retain_ports, 1'b1, "retain");
    chk_v(clk_en, 4'h0, "idle clocks");
    @(posedge clock);
    mode_write <= 1'b1;
    mode_wdata <= ocs_pkg::MODE_SLOW;
    port_req <= 1'b1;
    port_sel <= 4'h2;
    @(posedge clock);
    mode_write <= 1'b0;
    port_req <= 1'b0;
    repeat (10) @(negedge clock);
    chk_v(reset_pin_n, 1'b1, "no wake from disabled port");
    chk_v(operating_mode_field, ocs_pkg::MODE_IDLE, "write in idle");
    @(posedge clock);
    rtc_req <= use_rtc;
    port_req <= !use_rtc;
    port_sel <= 4'h3;
    @(posedge clock);
    rtc_req <= 1'b0;
    port_req <= 1'b0;
    repeat (5) begin
      @(negedge clock);
      if (reset_pin_n === 1'b0) break;
    end
    chk_v(reset_pin_n, 1'b0, "wake reset start");
    while (reset_pin_n !== 1'b1 && low < 40) begin
      @(negedge clock);
      low++;
    end
    chk_n(low, 13, "wake reset length");
    repeat (2) @(negedge clock);
    chk_v(operating_mode_field, ocs_pkg::MODE_FAST, "mode after wake");
    chk_v(core_reset, 1'b0, "core out of reset");
    $display("test idle wake rtc=%0b done", use_rtc);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("FAIL %0t timeout", $time);
      stop_test();
    end
  end

  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    factor_write <= 1'b1;
    multiplication_factor <= 4'h1;
    @(posedge clock);
    factor_write <= 1'b0;
    repeat (40) @(negedge clock);
    chk_v(pll_control_reg, 4'h1, "factor");
    chk_v(pll_lock_flag, 1'b1, "lock flag");
    chk_v(lock_output_pin, 1'b1, "lock pin");
    @(posedge clock);
    lock_output_select <= 2'h1;
    @(negedge clock);
    chk_v(lock_output_pin, 1'b0, "lock pin deselected");
    $display("test lock done");
    foreach (rows[i]) begin
      set_mode(rows[i].mode, rows[i].m);
      repeat (40) @(negedge clock);
      chk_v(operating_mode_field, rows[i].mode, "mode field");
      measure();
      chk_n(cnt[0], rows[i].bus, "bus rate");
      chk_n(cnt[1], rows[i].io, "io rate");
      chk_n(cnt[2], rows[i].f0, "f0 rate");
      chk_n(cnt[3], rows[i].f1, "f1 rate");
      chk_n(cnt[5], cnt[4] / 2, "chain halving");
      $display("test mode row %0d done", i);
    end
    set_mode(ocs_pkg::MODE_SLOW, 4'h1);
    @(negedge clock);
    b = clock_output_one;
    repeat (4) begin
      repeat (2) @(negedge clock);
      chk_v(clock_output_one, !b, "output one in slow");
      b = clock_output_one;
    end
    clock_out_case(7'h55, 2'h1, 20, 20);
    clock_out_case(7'h74, 2'h3, 12, 12);
    clock_out_case(7'h35, 2'h0, 0, 30);
    set_mode(ocs_pkg::MODE_FAST, 4'h1);
    idle_wake(1'b0);
    idle_wake(1'b1);
    set_mode(ocs_pkg::MODE_SLOW, 4'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk_v(operating_mode_field, ocs_pkg::MODE_FAST, "mode after reset");
    chk_v(pll_control_reg, 4'h0, "factor after reset");
    chk_v(reset_pin_n, 1'b1, "pin after reset");
    $display("test reset done");
    stop_test();
  end
endmodule
